// ==== core/ext_irq_pkg.sv ====
// Constants for the external pin and pin-change interrupt block
package ext_irq_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_PCMASK0  = 8'h27;
  localparam logic [7:0] IDX_PCMASK1  = 8'h28;
  localparam logic [7:0] IDX_PCMASK2  = 8'h29;
  localparam logic [7:0] IDX_CTRL     = 8'h36;
  localparam logic [7:0] IDX_ENMASK   = 8'h3B;
  localparam logic [7:0] IDX_FLAGS    = 8'h3A;
  localparam logic [7:0] IDX_GLOBAL   = 8'h3F;
  localparam logic [7:0] IDX_IRQMASK  = 8'h3C;
  // Byte addresses of the registers
  localparam logic [11:0] ADDR_PCMASK0 = {2'b00, IDX_PCMASK0, 2'b00};
  localparam logic [11:0] ADDR_PCMASK1 = {2'b00, IDX_PCMASK1, 2'b00};
  localparam logic [11:0] ADDR_PCMASK2 = {2'b00, IDX_PCMASK2, 2'b00};
  localparam logic [11:0] ADDR_CTRL    = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_ENMASK  = {2'b00, IDX_ENMASK, 2'b00};
  localparam logic [11:0] ADDR_FLAGS   = {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_GLOBAL  = {2'b00, IDX_GLOBAL, 2'b00};
  localparam logic [11:0] ADDR_IRQMASK = {2'b00, IDX_IRQMASK, 2'b00};
  // Writable bits of each register
  localparam logic [7:0] WMASK_PCMASK0 = 8'hFF;
  localparam logic [7:0] WMASK_PCMASK1 = 8'h0F;
  localparam logic [7:0] WMASK_PCMASK2 = 8'h3F;
  localparam logic [7:0] WMASK_CTRL    = 8'h73;
  localparam logic [7:0] WMASK_EVENTS  = 8'h78;
  // Field positions
  localparam int EXT_BIT = 6;
  localparam int GRP2_BIT = 5;
  localparam int GRP1_BIT = 4;
  localparam int GRP0_BIT = 3;
  localparam int GLOBAL_BIT = 7;
  // Reset value of every register
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Sense select encodings
  localparam logic [1:0] SENSE_LOW  = 2'b00;
  localparam logic [1:0] SENSE_ANY  = 2'b01;
  localparam logic [1:0] SENSE_FALL = 2'b10;
  localparam logic [1:0] SENSE_RISE = 2'b11;
  // Number of pin-change inputs
  localparam int N_CHANGE = 18;
  // Dispatch state encodings
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } disp_state_t;
endpackage

// ==== core/ext_pin_change_irq.sv ====
// External pin and pin-change interrupt logic with APB registers
// How it works
// - Control bits 1:0 pick sense mode
// - Pin sampled before edge detection
// - External request needs enable and global flag
// - Output-configured pin still raises request
// - Group 2 covers inputs 17 to 12
// - Group 1 covers inputs 11 to 8
// - Group 0 covers inputs 7 to 0
// - External flag bit 6 sets on activity
// - Flags clear on service or one-write
// - External flag reads zero in level mode
// - Group flags bits 5,4,3 set on change
// - Pin needs own mask and group enable
// - Mask bits map onto group inputs
// - Reserved bits read as zero
// - Pin-change detection on all eighteen inputs
// - Edges and low level both need clock
// - Low level keeps requesting while low
`timescale 1ns/10ps
module ext_pin_change_irq
  import ext_irq_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          external_irq_pin,
  input  wire logic [ext_irq_pkg::N_CHANGE-1:0] change_input_n,
  input  wire logic                          service_ack,
  input  wire logic [1:0]                    service_vector,
  output logic                               ext_request,
  output logic                               group0_request,
  output logic                               group1_request,
  output logic                               group2_request,
  output logic                               irq
);
  import ext_irq_pkg::*;

  // Timing in short:
  //   Pins pass two flops, then one more flop keeps the prior sample.
  //   A pin change shows in its flag three edges after it reaches the pin.
  //   Requests to dispatch follow the flags one edge later.
  //   Level mode builds its request straight from the synced pin, so the
  //   external flag is held at zero there and never reads as set.
  //   The APB answer comes one cycle after the setup edge, no more waits.
  //   Read data is latched at the setup edge and stands with pready.
  //   Writes land at the edge that ends the access phase.
  // Hazards and limits:
  //   Edge and change detection need pclk running; this block does not
  //   wake anything by itself, a sleeping core must keep pclk alive.
  //   Pulses shorter than one clock period may fall between two edges.
  //   A flag clear and a new event in one cycle leave the flag set, so an
  //   event that lands during a clear is never dropped.
  //   Detection stays quiet until the sync chains hold real samples, so a
  //   pin that idles high cannot fake an edge just after reset.
  //   Only byte lane 0 carries data; a write with its strobe low is dropped.
  //   Unmapped addresses answer with an error, read zero and ignore writes.
  //   The sleep bits of the control register are only stored here.
  // Trade-off: every output comes from a flop, which costs one cycle of
  //   latency on irq and the requests but keeps them glitch free.

  // All state of the block in one record
  typedef struct packed {
    logic [7:0]          pcmask0;      // Group 0 per-pin mask
    logic [7:0]          pcmask1;      // Group 1 per-pin mask
    logic [7:0]          pcmask2;      // Group 2 per-pin mask
    logic [7:0]          ctrl;         // Sense select and sleep bits
    logic [7:0]          enmask;       // Interrupt enable mask
    logic [7:0]          flags;        // Sticky event flags
    logic [7:0]          global_reg;   // Global interrupt flag in bit 7
    logic [7:0]          irqmask;      // Mask onto the irq output
    logic [1:0]          ext_sync;     // Synchroniser for external pin
    logic                ext_prev;     // Previous synced sample
    logic [N_CHANGE-1:0] chg_sync1;    // First stage for change inputs
    logic [N_CHANGE-1:0] chg_sync2;    // Second stage for change inputs
    logic [N_CHANGE-1:0] chg_prev;     // Previous synced samples
    logic                primed;       // Previous samples valid
    logic [1:0]          warm;         // Fill count of the sync chains
    logic [31:0]         rdata;        // Registered read data
    logic                ready;        // Access phase answer
    logic                slverr;       // Unmapped address answer
    logic                ext_req;      // External request out
    logic [2:0]          grp_req;      // Group requests out
    logic                irq_out;      // Combined interrupt out
  } state_t;

  state_t cur;        // Registered state
  state_t next_state; // Next state

  // Edge and change detection results
  logic [N_CHANGE-1:0] pin_change;
  logic [2:0]          grp_hit;
  logic                ext_event;
  logic                level_low;
  logic                wr_go;
  logic                rd_go;
  logic [7:0]          wbyte;
  logic [7:0]          flags_read;
  logic [7:0]          clr_vec;
  logic                mapped;

  // Per-pin change detection, one comparator per input
  genvar gi;
  generate
    for (gi = 0; gi < N_CHANGE; gi++) begin : g_chg
      // Only the second stage and prior sample are compared
      assign pin_change[gi] = cur.primed & (cur.chg_sync2[gi] ^ cur.chg_prev[gi]);
    end
  endgenerate

  // Group hits gated by per-pin masks
  always_comb begin
    grp_hit[0] = |(pin_change[7:0] & cur.pcmask0);
    grp_hit[1] = |(pin_change[11:8] & cur.pcmask1[3:0]);
    grp_hit[2] = |(pin_change[17:12] & cur.pcmask2[5:0]);
  end

  // External pin sense decode on the synchronised sample
  always_comb begin
    level_low = (cur.ctrl[1:0] == SENSE_LOW);
    case (cur.ctrl[1:0])
      SENSE_ANY:  ext_event = cur.primed & (cur.ext_sync[1] ^ cur.ext_prev);
      SENSE_FALL: ext_event = cur.primed & cur.ext_prev & ~cur.ext_sync[1];
      SENSE_RISE: ext_event = cur.primed & ~cur.ext_prev & cur.ext_sync[1];
      default:    ext_event = 1'b0;
    endcase
  end

  // Bus decode
  always_comb begin
    // A write with its lane 0 strobe low leaves every register alone
    wr_go = psel & penable & pwrite & cur.ready & pstrb[0];
    rd_go = psel & ~penable & ~pwrite;
    wbyte = pwdata[7:0];
    mapped = (paddr == ADDR_PCMASK0) | (paddr == ADDR_PCMASK1) |
             (paddr == ADDR_PCMASK2) | (paddr == ADDR_CTRL) |
             (paddr == ADDR_ENMASK) | (paddr == ADDR_FLAGS) |
             (paddr == ADDR_GLOBAL) | (paddr == ADDR_IRQMASK);
    // Level mode hides the external flag
    flags_read = cur.flags & WMASK_EVENTS;
    if (level_low) begin
      flags_read[EXT_BIT] = 1'b0;
    end
  end

  // Next-state logic for registers, detectors and outputs
  always_comb begin
    next_state = cur;
    clr_vec = 8'h00;
    // Synchronisers: first stage feeds only the second
    next_state.ext_sync  = {cur.ext_sync[0], external_irq_pin};
    next_state.ext_prev  = cur.ext_sync[1];
    next_state.chg_sync1 = change_input_n;
    next_state.chg_sync2 = cur.chg_sync1;
    next_state.chg_prev  = cur.chg_sync2;
    // Compare only once the chains hold real pin samples
    next_state.warm      = {cur.warm[0], 1'b1};
    next_state.primed    = cur.warm[1];
    // APB answer: no wait state, ready in the first access cycle
    next_state.ready  = psel & ~penable;
    next_state.slverr = psel & ~penable & ~mapped;
    if (rd_go) begin
      case (paddr)
        ADDR_PCMASK0: next_state.rdata = {24'h00_0000, cur.pcmask0};
        ADDR_PCMASK1: next_state.rdata = {24'h00_0000, cur.pcmask1 & WMASK_PCMASK1};
        ADDR_PCMASK2: next_state.rdata = {24'h00_0000, cur.pcmask2 & WMASK_PCMASK2};
        ADDR_CTRL:    next_state.rdata = {24'h00_0000, cur.ctrl};
        ADDR_ENMASK:  next_state.rdata = {24'h00_0000, cur.enmask & WMASK_EVENTS};
        ADDR_FLAGS:   next_state.rdata = {24'h00_0000, flags_read};
        ADDR_GLOBAL:  next_state.rdata = {24'h00_0000, cur.global_reg};
        ADDR_IRQMASK: next_state.rdata = {24'h00_0000, cur.irqmask};
        default:      next_state.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes take effect on the completing edge
    if (wr_go) begin
      case (paddr)
        ADDR_PCMASK0: next_state.pcmask0 = wbyte & WMASK_PCMASK0;
        ADDR_PCMASK1: next_state.pcmask1 = wbyte & WMASK_PCMASK1;
        ADDR_PCMASK2: next_state.pcmask2 = wbyte & WMASK_PCMASK2;
        ADDR_CTRL:    next_state.ctrl    = wbyte & WMASK_CTRL;
        ADDR_ENMASK:  next_state.enmask  = wbyte & WMASK_EVENTS;
        ADDR_FLAGS:   clr_vec            = wbyte & WMASK_EVENTS;
        ADDR_GLOBAL:  next_state.global_reg = wbyte & 8'h80;
        ADDR_IRQMASK: next_state.irqmask = wbyte & WMASK_EVENTS;
        default:      clr_vec            = 8'h00;
      endcase
    end
    // Entering a service routine clears that vector's flag
    if (service_ack) begin
      case (service_vector)
        2'd0:    clr_vec[EXT_BIT]  = 1'b1;
        2'd1:    clr_vec[GRP0_BIT] = 1'b1;
        2'd2:    clr_vec[GRP1_BIT] = 1'b1;
        default: clr_vec[GRP2_BIT] = 1'b1;
      endcase
    end
    // Clear first, then set so a same-cycle event survives
    next_state.flags = cur.flags & ~clr_vec;
    if (ext_event) begin
      next_state.flags[EXT_BIT] = 1'b1;
    end
    if (level_low) begin
      next_state.flags[EXT_BIT] = 1'b0;
    end
    if (grp_hit[0]) next_state.flags[GRP0_BIT] = 1'b1;
    if (grp_hit[1]) next_state.flags[GRP1_BIT] = 1'b1;
    if (grp_hit[2]) next_state.flags[GRP2_BIT] = 1'b1;
    // Requests to dispatch need enable and the global flag
    next_state.ext_req = cur.global_reg[GLOBAL_BIT] & cur.enmask[EXT_BIT] &
                         (level_low ? ~cur.ext_sync[1] : cur.flags[EXT_BIT]);
    next_state.grp_req[0] = cur.global_reg[GLOBAL_BIT] & cur.enmask[GRP0_BIT] &
                            cur.flags[GRP0_BIT];
    next_state.grp_req[1] = cur.global_reg[GLOBAL_BIT] & cur.enmask[GRP1_BIT] &
                            cur.flags[GRP1_BIT];
    next_state.grp_req[2] = cur.global_reg[GLOBAL_BIT] & cur.enmask[GRP2_BIT] &
                            cur.flags[GRP2_BIT];
    // Irq follows unmasked flags
    next_state.irq_out = |(flags_read & cur.irqmask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign prdata         = cur.rdata;
  assign pready         = cur.ready;
  assign pslverr        = cur.slverr;
  assign ext_request    = cur.ext_req;
  assign group0_request = cur.grp_req[0];
  assign group1_request = cur.grp_req[1];
  assign group2_request = cur.grp_req[2];
  assign irq            = cur.irq_out;

  // Assertions share the bus clock and sleep through reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Rising edge while in rise mode sets the flag next cycle
  AST_RISE_SETS: assert property (
    (cur.ctrl[1:0] == SENSE_RISE && cur.primed && !cur.ext_prev && cur.ext_sync[1] && !wr_go)
    |=> cur.flags[EXT_BIT]) else $error("rise did not set flag");

  // Level mode hides the external flag from software
  AST_LEVEL_FLAG_ZERO: assert property (
    (cur.ctrl[1:0] == SENSE_LOW)
    |-> (flags_read[EXT_BIT] == 1'b0)) else $error("level flag visible");

  // A held low level keeps the request up
  AST_LEVEL_REQ: assert property (
    (level_low && !cur.ext_sync[1] && cur.enmask[EXT_BIT] && cur.global_reg[GLOBAL_BIT])
    |=> ext_request) else $error("low level not requested");

  // No global flag, no external or group 0 request
  AST_NO_GLOBAL: assert property (
    (!cur.global_reg[GLOBAL_BIT] && !wr_go)
    |=> (!ext_request && !group0_request)) else $error("request without global flag");

  // A masked-in change on group 0 sets its flag
  AST_GRP0: assert property (
    (|(pin_change[7:0] & cur.pcmask0))
    |=> cur.flags[GRP0_BIT]) else $error("group 0 flag missed");

  // An all-zero group 2 mask keeps its flag down
  AST_GRP2_MASKED: assert property (
    (cur.pcmask2 == 8'h00 && !cur.flags[GRP2_BIT] && !(wr_go && paddr == ADDR_PCMASK2))
    |=> !cur.flags[GRP2_BIT]) else $error("masked group 2 set");

  // Writing a one clears a flag that is not set again
  AST_CLEAR: assert property (
    (wr_go && paddr == ADDR_FLAGS && pstrb[0] && pwdata[GRP1_BIT] && !grp_hit[1])
    |=> !cur.flags[GRP1_BIT]) else $error("write one did not clear");

  // Reserved flag and group 1 mask bits never hold a one
  AST_RESERVED: assert property (
    (cur.flags[7] == 1'b0) && (cur.flags[2:0] == 3'b000)
    && (cur.pcmask1[7:4] == 4'h0)) else $error("reserved bit set");

  // The prior sample trails the synced pin by one cycle
  AST_SYNC_DELAY: assert property (
    (cur.primed && $rose(cur.ext_sync[1]))
    |-> ##1 cur.ext_prev) else $error("prior sample lag wrong");

  // Falling edge while in fall mode sets the flag next cycle
  AST_FALL_SETS: assert property (
    (cur.ctrl[1:0] == SENSE_FALL && cur.primed && cur.ext_prev && !cur.ext_sync[1])
    |=> cur.flags[EXT_BIT]) else $error("fall did not set flag");

  // Any change while in toggle mode sets the flag next cycle
  AST_ANY_SETS: assert property (
    (cur.ctrl[1:0] == SENSE_ANY && cur.primed && (cur.ext_prev != cur.ext_sync[1]))
    |=> cur.flags[EXT_BIT]) else $error("toggle did not set flag");

  // A masked-in change on group 1 sets its flag
  AST_GRP1: assert property (
    (|(pin_change[11:8] & cur.pcmask1[3:0]))
    |=> cur.flags[GRP1_BIT]) else $error("group 1 flag missed");

  // A masked-in change on group 2 sets its flag
  AST_GRP2: assert property (
    (|(pin_change[17:12] & cur.pcmask2[5:0]))
    |=> cur.flags[GRP2_BIT]) else $error("group 2 flag missed");

  // Entering the group 0 handler clears its flag
  AST_SERVICE_CLEAR: assert property (
    (service_ack && service_vector == 2'd1 && !grp_hit[0])
    |=> !cur.flags[GRP0_BIT]) else $error("service did not clear");

  // Edge flag with enable and global flag raises the request
  AST_EXT_REQ: assert property (
    (!level_low && cur.global_reg[GLOBAL_BIT] && cur.enmask[EXT_BIT] && cur.flags[EXT_BIT])
    |=> ext_request) else $error("external request missed");

  // Group 0 flag with enable and global flag raises the request
  AST_GRP_REQ: assert property (
    (cur.global_reg[GLOBAL_BIT] && cur.enmask[GRP0_BIT] && cur.flags[GRP0_BIT])
    |=> group0_request) else $error("group 0 request missed");

  // Without its group enable group 2 never requests
  AST_NO_ENABLE: assert property (
    !cur.enmask[GRP2_BIT]
    |=> !group2_request) else $error("disabled group 2 requested");

  // A high pin in level mode drops the request
  AST_LEVEL_DROP: assert property (
    (level_low && cur.ext_sync[1])
    |=> !ext_request) else $error("level request without low pin");

  // Nothing is detected before the sync chains are filled
  AST_PRIMED_QUIET: assert property (
    !cur.primed
    |-> (!ext_event && pin_change == '0)) else $error("edge seen before priming");

  // Read data carries only the low byte lane
  AST_RDATA_UPPER: assert property (
    pready
    |-> (prdata[31:8] == 24'h00_0000)) else $error("upper read bits set");

  // Reserved enable and group 2 mask bits stay zero
  AST_ENMASK_RSVD: assert property (
    (cur.enmask[7] == 1'b0) && (cur.enmask[2:0] == 3'b000)
    && (cur.pcmask2[7:6] == 2'b00)) else $error("reserved enable bit set");

  // Level mode never produces an edge event
  AST_LOW_NO_EVENT: assert property (
    level_low
    |-> !ext_event) else $error("edge event in level mode");

  // An all-zero group 1 mask keeps its flag down
  AST_GRP1_MASK: assert property (
    (cur.pcmask1[3:0] == 4'h0 && !cur.flags[GRP1_BIT] && !(wr_go && paddr == ADDR_PCMASK1))
    |=> !cur.flags[GRP1_BIT]) else $error("masked group 1 set");

  // Prior change samples trail the second stage by one cycle
  AST_CHG_LAG: assert property (
    cur.primed
    |=> (cur.chg_prev == $past(cur.chg_sync2))) else $error("change sample lag wrong");

  // No global flag, no group 1 or 2 request
  AST_NO_GLOBAL_GRP: assert property (
    (!cur.global_reg[GLOBAL_BIT] && !wr_go)
    |=> (!group1_request && !group2_request)) else $error("group request without global flag");
endmodule

// ==== testbench/ext_pins.sv ====
// Model of the outside world that drives the external pin and the pin-change inputs
`timescale 1ns/10ps
module ext_pins (
  input  wire logic        pclk,
  output logic             ext_pin,
  output logic [17:0]      chg_pins
);
  // External pin idles high as with a pull-up; change inputs start low
  initial begin
    ext_pin  = 1'b1;
    chg_pins = 18'h0_0000;
  end
  // New level, held two clocks so the sampler cannot miss it
  task automatic set_ext(input logic v);
    @(posedge pclk);
    ext_pin <= v;
    repeat (2) @(posedge pclk);
  endtask
  // Flip one pin-change input and hold it
  task automatic toggle(input int i);
    @(posedge pclk);
    chg_pins[i] <= ~chg_pins[i];
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the external pin and pin-change interrupt block
`timescale 1ns/10ps
module testbench;
  import ext_irq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite; // Bus control
  logic [11:0] paddr;      // Byte address
  logic [31:0] pwdata;     // Write data
  logic [3:0]  pstrb;      // Lane strobes, lane 0 only
  logic [31:0] prdata;     // Read data
  logic        pready, pslverr, service_ack; // Answer and service strobe
  logic [1:0]  service_vector; // Serviced source
  logic        ext_pin, ext_request, group0_request, group1_request, group2_request, irq;
  logic [17:0] chg_pins;   // Pin-change inputs
  int          n_mismatch = 0; // Mismatches
  int          cmp_count = 0;  // Comparisons
  logic [31:0] rd;         // Scratch read data
  logic        err;        // Scratch error flag
  logic [3:0]  wstrb = 4'h1; // Lane strobes used by writes
  logic [11:0] ra[6] = '{ADDR_PCMASK0, ADDR_PCMASK1, ADDR_PCMASK2, ADDR_CTRL, ADDR_ENMASK,
                         ADDR_IRQMASK};
  logic [7:0]  rm[6] = '{8'hFF, 8'h0F, 8'h3F, 8'h73, 8'h78, 8'h78};

  ext_pin_change_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_irq_pin(ext_pin), .change_input_n(chg_pins),
    .service_ack(service_ack), .service_vector(service_vector), .ext_request(ext_request),
    .group0_request(group0_request), .group1_request(group1_request),
    .group2_request(group2_request), .irq(irq));
  ext_pins u_pins (.pclk(pclk), .ext_pin(ext_pin), .chg_pins(chg_pins));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    pstrb <= w ? wstrb : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
  endtask
  // Reset values, unmapped access, writable and reserved bits
  task automatic t_regs();
    for (int i = 0; i < 6; i++) rdchk(ra[i], 8'h00);
    rdchk(ADDR_FLAGS, 8'h00);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 8'hFF);
      rdchk(ra[i], rm[i]);
      wr(ra[i], 8'h00);
    end
    // A write with lane 0 strobe low must not land
    wr(ADDR_PCMASK0, 8'h5A);
    wstrb = 4'h0;
    wr(ADDR_PCMASK0, 8'hFF);
    wstrb = 4'h1;
    rdchk(ADDR_PCMASK0, 8'h5A);
    wr(ADDR_PCMASK0, 8'h00);
    apb(1'b1, 12'h000, 32'h0000_00FF);
    chk({31'h0, err}, 32'h0000_0001);
  endtask
  // Each edge mode against a falling and a rising pin, flag cleared by a one
  task automatic t_edge();
    logic [1:0] m[3] = '{SENSE_ANY, SENSE_FALL, SENSE_RISE};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {6'h0, m[i]});
      u_pins.set_ext(1'b0);
      cyc(6);
      rdchk(ADDR_FLAGS, (m[i] != SENSE_RISE) ? 8'h40 : 8'h00);
      wr(ADDR_FLAGS, 8'h00);
      rdchk(ADDR_FLAGS, (m[i] != SENSE_RISE) ? 8'h40 : 8'h00);
      wr(ADDR_FLAGS, 8'h40);
      rdchk(ADDR_FLAGS, 8'h00);
      u_pins.set_ext(1'b1);
      cyc(6);
      rdchk(ADDR_FLAGS, (m[i] != SENSE_FALL) ? 8'h40 : 8'h00);
      wr(ADDR_FLAGS, 8'h40);
    end
  endtask
  // Low level: request needs the global flag, lasts while low, flag stays clear
  task automatic t_level();
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_ENMASK, 8'h40);
    u_pins.set_ext(1'b0);
    cyc(6);
    chk({31'h0, ext_request}, 32'h0000_0000);
    wr(ADDR_GLOBAL, 8'h80);
    cyc(12);
    chk({31'h0, ext_request}, 32'h0000_0001);
    rdchk(ADDR_FLAGS, 8'h00);
    u_pins.set_ext(1'b1);
    cyc(6);
    chk({31'h0, ext_request}, 32'h0000_0000);
    wr(ADDR_ENMASK, 8'h00);
  endtask
  // Every input reaches its own group flag and request
  task automatic t_groups();
    int g;
    wr(ADDR_PCMASK0, 8'hFF);
    wr(ADDR_PCMASK1, 8'h0F);
    wr(ADDR_PCMASK2, 8'h3F);
    wr(ADDR_ENMASK, 8'h38);
    for (int i = 0; i < 18; i++) begin
      g = (i < 8) ? 0 : (i < 12) ? 1 : 2;
      u_pins.toggle(i);
      cyc(6);
      rdchk(ADDR_FLAGS, 8'h08 << g);
      chk({29'h0, group2_request, group1_request, group0_request}, 32'h1 << g);
      wr(ADDR_FLAGS, 8'h08 << g);
    end
    wr(ADDR_PCMASK0, 8'hFE);
    u_pins.toggle(0);
    cyc(6);
    rdchk(ADDR_FLAGS, 8'h00);
    u_pins.toggle(1);
    cyc(6);
    wr(ADDR_ENMASK, 8'h30);
    cyc(3);
    chk({31'h0, group0_request}, 32'h0000_0000);
    wr(ADDR_ENMASK, 8'h38);
  endtask
  // Processor entering the handler of one vector
  task automatic ack(input logic [1:0] v);
    @(posedge pclk);
    service_ack <= 1'b1;
    service_vector <= v;
    @(posedge pclk);
    service_ack <= 1'b0;
  endtask
  // Output mask gates irq; entering the handler clears the flag
  task automatic t_service();
    wr(ADDR_IRQMASK, 8'h08);
    cyc(2);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(ADDR_IRQMASK, 8'h00);
    cyc(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ADDR_IRQMASK, 8'h08);
    ack(2'd1);
    cyc(3);
    rdchk(ADDR_FLAGS, 8'h00);
    chk({30'h0, irq, group0_request}, 32'h0000_0000);
    u_pins.toggle(8);
    u_pins.toggle(12);
    cyc(6);
    ack(2'd2);
    rdchk(ADDR_FLAGS, 8'h20);
    ack(2'd3);
    rdchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, {6'h0, SENSE_ANY});
    wr(ADDR_ENMASK, 8'h78);
    u_pins.set_ext(1'b0);
    cyc(6);
    chk({31'h0, ext_request}, 32'h0000_0001);
    ack(2'd0);
    cyc(3);
    rdchk(ADDR_FLAGS, 8'h00);
    chk({31'h0, ext_request}, 32'h0000_0000);
  endtask
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #1200000;
    n_mismatch++;
    end_sim();
  end
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; pstrb = 4'h0; service_ack = 1'b0; service_vector = 2'd0;
    cyc(16);
    presetn <= 1'b1;
    cyc(2);
    t_regs();
    t_edge();
    t_level();
    t_groups();
    t_service();
    end_sim();
  end
endmodule
